/* File: verilog/rtc_core.sv */
/*
 Real time clock core: indirect register port, time and calendar update,
 alarm compare, three interrupt sources, oscillator control, square wave.
 Assumes host strobes are synchronous to clk; IRQ is open drain outside.
*/
`timescale 1ns/1ps
module rtc_core #(
   parameter int unsigned OSC_DIV = rtc_pkg::OSC_DIV_DEF
) (
   input  wire logic          clk,      // System clock, 200 MHz
   input  wire logic          sys_rst,  // Asynchronous reset, active high
   input  rtc_pkg::host_bus_t bus,      // Select, strobes, A0, write data
   output logic [7:0]         d_out,    // Read data
   output logic               d_oe,     // High while driving read data
   output logic               irq_n_o,  // Interrupt pin level, active low
   output logic               irq_oe,   // High while pulling the pin low
   output logic               sqw_o     // Square wave output
);
   import rtc_pkg::*;

   typedef struct packed {
      bus_phase_t      phase;
      logic [5:0]      addr;
      logic            rd_c;
      logic [9:0][7:0] tm;
      logic [6:0]      reg_a;
      logic [7:0]      reg_b;
      logic [2:0]      flags;
      logic [2:0]      pend;
      logic            irq;
      logic            irq_n;
      logic [7:0]      dout;
      logic            doe;
      logic            sqw;
   } core_st_t;

   core_st_t st;
   core_st_t n;
   div_out_t div;
   logic     rd_go;
   logic     wr_go;

   assign rd_go = !bus.sel_n && !bus.rd_n;
   assign wr_go = !bus.sel_n && !bus.wr_n;

   function automatic logic [7:0] to_bin(input logic [7:0] v,
                                         input logic bin);
      to_bin = bin ? v : 8'(v[7:4]) * 8'h0a + 8'(v[3:0]);
   endfunction : to_bin

   function automatic logic [7:0] to_fmt(input logic [7:0] b,
                                         input logic bin);
      to_fmt = bin ? b : {4'(b / 8'h0a), 4'(b % 8'h0a)};
   endfunction : to_fmt

   function automatic logic [7:0] month_days(input logic [7:0] mo,
                                             input logic [7:0] yr);
      case (mo)
         8'h02: month_days = (yr[1:0] == 2'h0) ? 8'h1d : 8'h1c;
         8'h04, 8'h06, 8'h09, 8'h0b: month_days = 8'h1e;
         default: month_days = 8'h1f;
      endcase
   endfunction : month_days

   function automatic logic alarm_hit(input logic [7:0] al,
                                      input logic [7:0] tv);
      alarm_hit = (al[7:6] == DONT_CARE) || (al == tv);
   endfunction : alarm_hit

   rate_divider #(
      .OSC_DIV (OSC_DIV)
   ) u_div (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .osc_ctl     (st.reg_a[6:4]),
      .rate_select (st.reg_a[3:0]),
      .div         (div)
   );

   always_comb begin
      logic       bin;
      logic       h24;
      logic       c;
      logic       pm;
      logic       clr;
      logic [7:0] s;
      logic [7:0] m;
      logic [7:0] hb;
      logic [7:0] dw;
      logic [7:0] dm;
      logic [7:0] mo;
      logic [7:0] yr;
      logic [7:0] rv;
      logic [2:0] ev;
      n   = st;
      bin = st.reg_b[B_DM];
      h24 = st.reg_b[B_24H];
      c   = 1'b0;
      pm  = 1'b0;
      clr = 1'b0;
      s   = '0;
      m   = '0;
      hb  = '0;
      dw  = '0;
      dm  = '0;
      mo  = '0;
      yr  = '0;
      rv  = '0;
      ev  = '0;
      ev[FLG_PF] = div.periodic;

      // Once-per-second advance of the time and calendar bytes
      if (div.second && !st.reg_b[B_SET]) begin
         s = to_bin({1'b0, st.tm[ADR_SEC][6:0]}, bin) + 8'h01;
         c = (s >= SEC_LIM);
         if (c) begin
            s = '0;
         end
         m = to_bin(st.tm[ADR_MIN], bin);
         if (c) begin
            m = m + 8'h01;
            c = (m >= SEC_LIM);
            if (c) begin
               m = '0;
            end
         end
         pm = st.tm[ADR_HOUR][7] && !h24;
         hb = to_bin({1'b0, st.tm[ADR_HOUR][6:0]}, bin);
         if (c && h24) begin
            hb = hb + 8'h01;
            c  = (hb >= HR24_LIM);
            if (c) begin
               hb = '0;
            end
         end else if (c) begin
            c = 1'b0;
            if (hb == HR12_TOP - 8'h01) begin
               hb = HR12_TOP;
               pm = !pm;
               c  = !pm;
            end else if (hb == HR12_TOP) begin
               hb = 8'h01;
            end else begin
               hb = hb + 8'h01;
            end
         end
         dw = st.tm[ADR_DOW];
         dm = to_bin(st.tm[ADR_DOM], bin);
         mo = to_bin(st.tm[ADR_MON], bin);
         yr = to_bin(st.tm[ADR_YEAR], bin);
         if (c) begin
            dw = (dw >= DOW_TOP) ? 8'h01 : dw + 8'h01;
            c  = (dm >= month_days(mo, yr));
            dm = c ? 8'h01 : dm + 8'h01;
         end
         if (c) begin
            c  = (mo >= MON_TOP);
            mo = c ? 8'h01 : mo + 8'h01;
         end
         if (c) begin
            yr = (yr >= YEAR_TOP) ? 8'h00 : yr + 8'h01;
         end
         rv = to_fmt(hb, bin);
         n.tm[ADR_SEC]  = to_fmt(s, bin);
         n.tm[ADR_MIN]  = to_fmt(m, bin);
         n.tm[ADR_HOUR] = h24 ? rv : {pm, rv[6:0]};
         n.tm[ADR_DOW]  = dw;
         n.tm[ADR_DOM]  = to_fmt(dm, bin);
         n.tm[ADR_MON]  = to_fmt(mo, bin);
         n.tm[ADR_YEAR] = to_fmt(yr, bin);
         ev[FLG_AF] = alarm_hit(st.tm[ADR_SEC_A], n.tm[ADR_SEC]) &&
                      alarm_hit(st.tm[ADR_MIN_A], n.tm[ADR_MIN]) &&
                      alarm_hit(st.tm[ADR_HR_A], n.tm[ADR_HOUR]);
         ev[FLG_UF] = 1'b1;
      end

      // Host port: A0 low selects the index, A0 high the data
      case (st.phase)
         PH_IDLE: begin
            if (rd_go) begin
               n.phase = PH_READ;
               n.doe   = 1'b1;
               n.rd_c  = bus.a0 && (st.addr == ADR_C);
               if (!bus.a0) begin
                  n.dout = {2'h0, st.addr};
               end else if (st.addr <= ADR_YEAR) begin
                  n.dout = st.tm[st.addr[3:0]];
               end else if (st.addr == ADR_A) begin
                  n.dout = {div.pre_update && !st.reg_b[B_SET], st.reg_a};
               end else if (st.addr == ADR_B) begin
                  n.dout = st.reg_b;
               end else if (st.addr == ADR_C) begin
                  n.dout = {st.irq, st.flags, 4'h0};
               end else if (st.addr == ADR_D) begin
                  n.dout = STAT_D;
               end else begin
                  n.dout = 8'h00;
               end
            end else if (wr_go) begin
               n.phase = PH_WRITE;
               if (!bus.a0) begin
                  n.addr = bus.data[5:0];
               end else if (st.addr == ADR_SEC) begin
                  n.tm[ADR_SEC] = {1'b0, bus.data[6:0]};
               end else if (st.addr <= ADR_YEAR) begin
                  n.tm[st.addr[3:0]] = bus.data;
               end else if (st.addr == ADR_A) begin
                  n.reg_a = bus.data[6:0];
               end else if (st.addr == ADR_B) begin
                  n.reg_b = bus.data;
                  if (bus.data[B_SET]) begin
                     n.reg_b[B_UIE] = 1'b0;
                  end
               end
            end
         end
         PH_READ: begin
            if (!rd_go) begin
               n.phase = PH_IDLE;
               n.doe   = 1'b0;
               clr     = st.rd_c;
            end
         end
         PH_WRITE: begin
            if (!wr_go) begin
               n.phase = PH_IDLE;
            end
         end
         default: begin
            n.phase = PH_IDLE;
         end
      endcase

      // Flags hold still while being read; events meanwhile wait in pend
      if (clr) begin
         n.flags = st.pend | ev;
         n.pend  = '0;
      end else if (n.phase == PH_READ && n.rd_c) begin
         n.pend = st.pend | ev;
      end else begin
         n.flags = st.flags | ev;
      end
      n.irq   = |(n.flags & n.reg_b[B_PIE:B_UIE]);
      n.irq_n = !n.irq;
      n.sqw   = st.reg_b[B_SQUARE_OUT_ENABLE] && div.square;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st       <= '0;
         st.phase <= PH_IDLE;
         st.tm    <= RST_TIME;
         st.reg_a <= RST_A;
         st.reg_b <= RST_B;
         st.irq_n <= 1'b1;
      end else begin
         st <= n;
      end
   end

   assign d_out   = st.dout;
   assign d_oe    = st.doe;
   assign irq_n_o = st.irq_n;
   assign irq_oe  = st.irq;
   assign sqw_o   = st.sqw;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   irq_pairs_a: assert property (
      st.irq == |(st.flags & st.reg_b[B_PIE:B_UIE]))
      else $error("irq does not match flag and enable pairs");
   interrupt_summary_flag_mirror_a: assert property (
      st.phase == PH_IDLE && rd_go && bus.a0 && st.addr == ADR_C
      |=> st.dout[C_INTERRUPT_SUMMARY_FLAG] == !$past(irq_n_o))
      else $error("flag bit 7 differs from irq pin");
   read_clear_a: assert property (
      st.phase == PH_READ && st.rd_c && !rd_go && st.pend == 3'h0 &&
      !div.second && !div.periodic |=> st.flags == 3'h0)
      else $error("flag read did not clear flags");
   read_stable_a: assert property (
      st.phase == PH_READ && st.rd_c && rd_go |=> $stable(st.flags))
      else $error("flags changed during flag read");
   enable_now_a: assert property (
      st.phase == PH_IDLE && !rd_go && wr_go && bus.a0 &&
      st.addr == ADR_B && !bus.data[B_SET] &&
      (|(bus.data[B_PIE:B_UIE] & st.flags))
      |=> !irq_n_o && irq_oe)
      else $error("enabling a set flag did not assert irq");
   poll_flag_a: assert property (
      div.periodic && st.phase == PH_IDLE && !rd_go |=> st.flags[FLG_PF])
      else $error("periodic event lost its flag");
   update_flag_a: assert property (
      div.second && !st.reg_b[B_SET] && st.phase == PH_IDLE && !rd_go
      |=> st.flags[FLG_UF])
      else $error("update ended flag not set");
   sqw_gate_a: assert property (
      !st.reg_b[B_SQUARE_OUT_ENABLE] |=> !sqw_o)
      else $error("square wave active while disabled");
   osc_stop_a: assert property (
      st.reg_a[6:4] != DV_RUN && $past(st.reg_a[6:4]) != DV_RUN
      |-> !div.second && !div.periodic)
      else $error("chain advanced while not running");
   hold_quiet_a: assert property (
      st.reg_a[6:5] == DV_HOLD_HI |=> !div.second ##1 !div.second)
      else $error("update while chain held in reset");
   dow_range_a: assert property (
      div.second && !st.reg_b[B_SET] && st.phase == PH_IDLE && !wr_go &&
      st.tm[ADR_DOW] >= 8'h01 && st.tm[ADR_DOW] <= DOW_TOP
      |=> st.tm[ADR_DOW] >= 8'h01 && st.tm[ADR_DOW] <= DOW_TOP)
      else $error("day of week left 1 to 7");
endmodule : rtc_core

/* File: verilog/rtc_pkg.sv */
/*
 Shared constants and carrier types of the real time clock core.
 Assumes a 200 MHz system clock and a 32.768 kHz timebase derived from it.
*/
package rtc_pkg;
   localparam int unsigned CLK_HZ      = 200_000_000;
   localparam int unsigned OSC_HZ      = 32_768;
   localparam int unsigned OSC_DIV_DEF = CLK_HZ / OSC_HZ;
   localparam int unsigned CHAIN_W     = 15;
   // Chain restarts half way so the first update comes 500 ms later
   localparam logic [14:0] CHAIN_PRESET = 15'h4000;
   localparam int unsigned UIP_LSB      = 3;

   // Indirect register addresses
   localparam logic [5:0] ADR_SEC   = 6'h00;
   localparam logic [5:0] ADR_SEC_A = 6'h01;
   localparam logic [5:0] ADR_MIN   = 6'h02;
   localparam logic [5:0] ADR_MIN_A = 6'h03;
   localparam logic [5:0] ADR_HOUR  = 6'h04;
   localparam logic [5:0] ADR_HR_A  = 6'h05;
   localparam logic [5:0] ADR_DOW   = 6'h06;
   localparam logic [5:0] ADR_DOM   = 6'h07;
   localparam logic [5:0] ADR_MON   = 6'h08;
   localparam logic [5:0] ADR_YEAR  = 6'h09;
   localparam logic [5:0] ADR_A     = 6'h0a;
   localparam logic [5:0] ADR_B     = 6'h0b;
   localparam logic [5:0] ADR_C     = 6'h0c;
   localparam logic [5:0] ADR_D     = 6'h0d;

   // Control register B fields
   localparam int unsigned B_SET  = 7;
   localparam int unsigned B_PIE  = 6;
   localparam int unsigned B_AIE  = 5;
   localparam int unsigned B_UIE  = 4;
   localparam int unsigned B_SQUARE_OUT_ENABLE = 3;
   localparam int unsigned B_DM   = 2;
   localparam int unsigned B_24H  = 1;
   // Flag positions, aligned with the enables in B
   localparam int unsigned FLG_PF = 2;
   localparam int unsigned FLG_AF = 1;
   localparam int unsigned FLG_UF = 0;
   localparam int unsigned C_INTERRUPT_SUMMARY_FLAG = 7;

   localparam logic [2:0] DV_RUN     = 3'h2;
   localparam logic [1:0] DV_HOLD_HI = 2'h3;
   localparam logic [3:0] RS_NONE    = 4'h0;
   localparam logic [3:0] RS_FAST    = 4'h3;
   localparam logic [1:0] DONT_CARE  = 2'h3;

   localparam logic [7:0] SEC_LIM  = 8'h3c;
   localparam logic [7:0] HR24_LIM = 8'h18;
   localparam logic [7:0] HR12_TOP = 8'h0c;
   localparam logic [7:0] DOW_TOP  = 8'h07;
   localparam logic [7:0] MON_TOP  = 8'h0c;
   localparam logic [7:0] YEAR_TOP = 8'h63;

   localparam logic [6:0] RST_A  = 7'h00;
   localparam logic [7:0] RST_B  = 8'h00;
   localparam logic [7:0] STAT_D = 8'h80;
   localparam logic [9:0][7:0] RST_TIME = {8'h00, 8'h01, 8'h01, 8'h01,
                                           8'h00, 8'h00, 8'h00, 8'h00,
                                           8'h00, 8'h00};

   typedef struct packed {
      logic       sel_n;
      logic       rd_n;
      logic       wr_n;
      logic       a0;
      logic [7:0] data;
   } host_bus_t;

   typedef struct packed {
      logic second;
      logic periodic;
      logic square;
      logic pre_update;
   } div_out_t;

   typedef enum logic [1:0] {PH_IDLE, PH_READ, PH_WRITE} bus_phase_t;
endpackage : rtc_pkg

/* File: verilog/rate_divider.sv */
/*
 Timebase prescaler, 15-stage up-counting chain and shared rate selector.
 Assumes osc_ctl and rate_select come from registers in the clk domain.
*/
`timescale 1ns/1ps
module rate_divider #(
   parameter int unsigned OSC_DIV = rtc_pkg::OSC_DIV_DEF
) (
   input  wire logic          clk,          // System clock
   input  wire logic          sys_rst,      // Asynchronous reset
   input  wire logic [2:0]    osc_ctl,      // Oscillator control field
   input  wire logic [3:0]    rate_select,  // Shared tap select
   output rtc_pkg::div_out_t  div           // Registered pulses and levels
);
   import rtc_pkg::*;

   localparam int unsigned PRE_W = $clog2(OSC_DIV);

   typedef struct packed {
      logic [PRE_W-1:0]   pre;
      logic [CHAIN_W-1:0] chain;
      div_out_t           out;
   } div_st_t;

   div_st_t            st;
   div_st_t            st_nxt;
   logic [CHAIN_W-1:0] wrap;

   // wrap[k]: stage k and all below roll over on the next tick
   genvar k;
   generate
      for (k = 0; k < CHAIN_W; k++) begin : g_tap
         assign wrap[k] = &st.chain[k:0];
      end
   endgenerate

   always_comb begin
      logic       osc_run;
      logic       chain_run;
      logic       tick;
      logic [3:0] tap;
      st_nxt    = st;
      osc_run   = (osc_ctl == DV_RUN) || (osc_ctl[2:1] == DV_HOLD_HI);
      chain_run = (osc_ctl == DV_RUN);
      tick      = osc_run && (st.pre == PRE_W'(OSC_DIV - 1));
      // Thirteen taps; codes 1 and 2 alias codes 8 and 9
      tap = (rate_select >= RS_FAST) ? rate_select - 4'h2
                                     : rate_select + 4'h5;
      if (!osc_run || tick) begin
         st_nxt.pre = '0;
      end else begin
         st_nxt.pre = st.pre + 1'b1;
      end
      if (osc_ctl[2:1] == DV_HOLD_HI) begin
         st_nxt.chain = CHAIN_PRESET;
      end else if (tick) begin
         st_nxt.chain = st.chain + 1'b1;
      end
      st_nxt.out.second   = chain_run && tick && wrap[CHAIN_W-1];
      st_nxt.out.periodic = chain_run && tick &&
                            (rate_select != RS_NONE) && wrap[tap];
      st_nxt.out.square   = chain_run && (rate_select != RS_NONE) &&
                            st_nxt.chain[tap];
      st_nxt.out.pre_update = chain_run && (&st.chain[CHAIN_W-1:UIP_LSB]);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '{pre: '0, chain: CHAIN_PRESET, out: '0};
      end else begin
         st <= st_nxt;
      end
   end

   assign div = st.out;
endmodule : rate_divider

/* File: testbench/host_model.sv */
/*
 Host processor model for the indexed byte port of the clock core.
 Assumes strobes are launched on the falling edge of the core's clock.
*/
`timescale 1ns/1ps
module host_model (
   input  wire logic          clk,    // Core clock
   output rtc_pkg::host_bus_t bus,    // Select, strobes, A0, data
   input  wire logic [7:0]    d_out,  // Read data from the core
   input  wire logic          d_oe    // Core drives read data
);
   import rtc_pkg::*;

   initial bus = '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a0: 1'b0,
                   data: 8'h00};

   // Strobe held over one sampling edge, then an idle cycle
   task automatic wr_byte(input logic a0, input logic [7:0] v);
      @(negedge clk);
      bus <= '{sel_n: 1'b0, rd_n: 1'b1, wr_n: 1'b0, a0: a0, data: v};
      @(negedge clk);
      bus <= '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a0: a0, data: ~v};
      @(negedge clk);
   endtask : wr_byte

   // Released data lines keep changing so stale values never match
   task automatic rd_byte(input logic a0, output logic [7:0] v,
                          output bit ok);
      int k;
      ok = 1'b0;
      @(negedge clk);
      bus <= '{sel_n: 1'b0, rd_n: 1'b0, wr_n: 1'b1, a0: a0,
               data: ~bus.data};
      for (k = 0; k < 8 && !ok; k++) begin
         @(negedge clk);
         ok = (d_oe === 1'b1);
      end
      v = d_out;
      bus <= '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, a0: a0,
               data: ~bus.data};
      @(negedge clk);
      @(negedge clk);
   endtask : rd_byte
endmodule : host_model

/* File: testbench/rtc_interrupts_oscillator_sqw_bench.sv */
/*
 Self-checking bench for the clock core: registers, flags, request pin,
 oscillator codes, square wave rates and the first update.
 Assumes the core's timebase divider is shortened to DIV clocks a tick.
*/
`timescale 1ns/1ps
module rtc_interrupts_oscillator_sqw_bench;
   import rtc_pkg::*;
   localparam int unsigned DIV = 4;
   logic       clk         = 1'b0;
   logic       sys_rst     = 1'b1;
   host_bus_t  bus;
   logic [7:0] d_out;
   logic       d_oe;
   logic       irq_n_o;
   logic       irq_oe;
   logic       sqw_o;
   int         fails       = 0;
   int         check_count = 0;
   int         seed        = 69294;

   always #2.5 clk = ~clk;

   rtc_core #(.OSC_DIV(DIV)) dut (.clk(clk), .sys_rst(sys_rst), .bus(bus),
      .d_out(d_out), .d_oe(d_oe), .irq_n_o(irq_n_o), .irq_oe(irq_oe),
      .sqw_o(sqw_o));
   host_model host (.clk(clk), .bus(bus), .d_out(d_out), .d_oe(d_oe));

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [7:0] rst_val(input int i);
      case (i)
         6, 7, 8: return 8'h01;
         13:      return STAT_D;
         default: return 8'h00;
      endcase
   endfunction : rst_val

   // Rate codes 1 and 2 repeat the rates of 8 and 9
   function automatic logic [15:0] sqw_period(input int rs);
      return 16'(DIV * (rs < 3 ? (1 << (rs + 6)) : (1 << (rs - 1))));
   endfunction : sqw_period

   task automatic reg_wr(input logic [5:0] idx, input logic [7:0] v);
      host.wr_byte(1'b0, {2'b00, idx});
      host.wr_byte(1'b1, v);
   endtask : reg_wr

   task automatic reg_chk(input logic [5:0] idx, input logic [7:0] exp,
                          input string what);
      logic [7:0] v;
      bit         ok;
      host.wr_byte(1'b0, {2'b00, idx});
      host.rd_byte(1'b1, v, ok);
      if (!ok) begin
         fails++;
         $display("Error read enable expected 1 seen 0");
         test_done();
      end
      check(what, {8'h00, v}, {8'h00, exp});
   endtask : reg_chk

   task automatic sqw_cycles(output int n);
      int k;
      n = 0;
      // Let a new rate or enable reach the pin before timing edges
      repeat (4) @(negedge clk);
      for (k = 0; k < 3000 && sqw_o !== 1'b0; k++) @(negedge clk);
      for (k = 0; k < 3000 && sqw_o !== 1'b1; k++) @(negedge clk);
      for (k = 0; k < 3000 && sqw_o === 1'b1; k++) begin
         @(negedge clk);
         n++;
      end
      for (k = 0; k < 3000 && sqw_o !== 1'b1; k++) begin
         @(negedge clk);
         n++;
      end
      if (n >= 2900) begin
         fails++;
         $display("Error sqw edge expected toggle seen none");
         test_done();
      end
   endtask : sqw_cycles

   initial begin
      logic [7:0] v;
      int         n;
      int         k;
      repeat (8) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      check("irq_n", {15'h0000, irq_n_o}, 16'h0001);
      check("irq_oe", {15'h0000, irq_oe}, 16'h0000);
      for (k = 0; k < 14; k++)
         reg_chk(6'(k), rst_val(k), "reset value");
      reg_chk(6'h20, 8'h00, "unmapped");
      reg_wr(ADR_D, 8'h00);
      reg_chk(ADR_D, STAT_D, "read only");
      v = 8'($random(seed));
      reg_wr(ADR_SEC, v);
      reg_chk(ADR_SEC, {1'b0, v[6:0]}, "seconds");
      reg_wr(ADR_SEC, 8'h00);
      // Random don't-care codes make every second an alarm
      for (k = 0; k < 3; k++) begin
         v = 8'hc0 | 8'($random(seed));
         reg_wr(6'(2 * k + 1), v);
         reg_chk(6'(2 * k + 1), v, "alarm byte");
      end
      reg_wr(ADR_A, 8'h03);
      repeat (200) @(negedge clk);
      reg_chk(ADR_C, 8'h00, "flags osc off");
      reg_wr(ADR_A, 8'h63);
      repeat (200) @(negedge clk);
      reg_chk(ADR_C, 8'h00, "flags chain held");
      reg_wr(ADR_A, 8'h23);
      repeat (100) @(negedge clk);
      // Stop the rate first so no event lands between the two reads
      reg_wr(ADR_A, 8'h20);
      check("irq_n", {15'h0000, irq_n_o}, 16'h0001);
      reg_chk(ADR_C, 8'h40, "periodic polled");
      reg_chk(ADR_C, 8'h00, "flags after read");
      reg_wr(ADR_A, 8'h23);
      repeat (40) @(negedge clk);
      reg_wr(ADR_A, 8'h20);
      reg_wr(ADR_B, 8'h20);
      check("irq_n", {15'h0000, irq_n_o}, 16'h0001);
      reg_wr(ADR_B, 8'h40);
      check("irq_n", {15'h0000, irq_n_o}, 16'h0000);
      check("irq_oe", {15'h0000, irq_oe}, 16'h0001);
      reg_chk(ADR_C, 8'hc0, "flags with request");
      check("irq_n", {15'h0000, irq_n_o}, 16'h0001);
      reg_chk(ADR_C, 8'h00, "stale flags");
      reg_wr(ADR_B, 8'h08);
      for (k = 1; k < 9; k++) begin
         reg_wr(ADR_A, 8'h20 | 8'(k));
         sqw_cycles(n);
         check("sqw period", 16'(n), sqw_period(k));
      end
      reg_wr(ADR_B, 8'h00);
      n = 0;
      for (k = 0; k < 600; k++) begin
         @(negedge clk);
         n += int'(sqw_o !== 1'b0);
      end
      check("sqw off", 16'(n), 16'h0000);
      reg_wr(ADR_B, 8'h08);
      sqw_cycles(n);
      check("sqw period kept", 16'(n), sqw_period(8));
      reg_wr(ADR_A, 8'h60);
      reg_wr(ADR_B, 8'h00);
      // Periodic flag left over from the rate sweep is read away here
      reg_chk(ADR_C, 8'h40, "flags before start");
      reg_wr(ADR_B, 8'h10);
      reg_wr(ADR_A, 8'h20);
      for (n = 0; n < 70000 && irq_n_o !== 1'b0; n++) @(negedge clk);
      check("first update", 16'(n >= 16384 * DIV - 16 &&
            n <= 16384 * DIV + 16), 16'h0001);
      reg_chk(ADR_C, 8'hb0, "update flags");
      reg_chk(ADR_SEC, 8'h01, "seconds advanced");
      test_done();
   end
endmodule : rtc_interrupts_oscillator_sqw_bench
